// ### bfs_cfg.svh
// Functional notes
// (RL1) Any selected trigger starts the failure supervision timer at once.
// (RL2) A running timer keeps running after its trigger drops.
// (RL3) Timer expiry before stop asserts the backup failure trip.
// (RL4) Detected breaker opening stops the timer without a failure trip.
// (RL5) Opening is seen by position, by low current, or both, per scheme.
// (RL6) Position scheme: no open report within the set time means failure.
// (RL7) Opening seen while triggers still active enters rejected, held while active.
// (RL8) Rejected returns to standby once every trigger has dropped.
// (RL9) Locking output rises with the failure trip and stays latched.
// (RL10) Only an explicit operator acknowledge clears the locking output.
// (RL11) Mode all: every trip assigned to the breaker starts supervision.
// (RL12) Mode external: only assigned external trips start supervision.
// (RL13) Mode current: only assigned current trips start supervision.
// (RL14) Mode none: only the extra trigger inputs start supervision.
// (RL15) Three extra trigger inputs start supervision regardless of assignment.
// (RL16) Four identical external protection stages, each enabled on its own.
// (RL17) Each stage turns alarm, trip and block inputs into own events; the code gives alarm and trip events only, block suppresses both.
// (RL18) A stage whose mode is not set to use ignores its inputs.
// (RL19) Intertripping turns a remote trip input into a local trip command.
// (RL20) Effective trigger is mode-selected trips ORed with the extra inputs.
`ifndef BFS_CFG_SVH
`define BFS_CFG_SVH

`define REG_CTRL          4'h0
`define REG_TIME          4'h4
`define REG_ACK           4'h8
`define REG_STATUS        4'hc

`define CTRL_MODE_LSB     0
`define CTRL_SCHEME_LSB   2
`define CTRL_EXP_LSB      4
`define CTRL_ITRIP_BIT    8
`define ACK_LOCK_BIT      0

`define CTRL_RST          32'h0000_0000
`define TIME_RST_US       32'h0000_c350

`define MODE_ALL          2'h0
`define MODE_EXTERNAL     2'h1
`define MODE_CURRENT      2'h2
`define MODE_NONE         2'h3

`define SCHEME_POSITION   2'h0
`define SCHEME_CURRENT    2'h1
`define SCHEME_BOTH       2'h2
`define SCHEME_EITHER     2'h3

`define US_NS             1000
`define REF_CLK_PERIOD_NS 4
`define US_CYCLES         16'(`US_NS / `REF_CLK_PERIOD_NS)

`endif

// ### bfs_pkg.sv
`default_nettype none
package bfs_pkg;
    typedef enum logic [1:0] {
        ST_STANDBY,
        ST_RUNNING,
        ST_TRIPPED,
        ST_REJECTED
    } sup_state_t;
    typedef logic [1:0] mode_field_t;
    typedef logic [1:0] scheme_field_t;
endpackage : bfs_pkg
`default_nettype wire

// ### breaker_failure_supervision.sv
`include "bfs_cfg.svh"
`default_nettype none
module breaker_failure_supervision
    import bfs_pkg::*;
#(
    parameter int          NUM_STAGES   = 4,
    parameter int          NUM_EXTRA    = 3,
    parameter logic [31:0] FAIL_TIME_US = `TIME_RST_US,
    parameter logic [15:0] TICK_CYCLES  = `US_CYCLES
) (
    // Clock and reset
    input  wire logic                  ref_clk,
    input  wire logic                  sys_rst,
    // Avalon-MM register slave
    input  wire logic [3:0]            avs_address,
    input  wire logic                  avs_read,
    input  wire logic                  avs_write,
    input  wire logic [31:0]           avs_writedata,
    output var  logic [31:0]           avs_readdata,
    output var  logic                  avs_waitrequest,
    // Trips assigned to the monitored breaker and extra trigger inputs
    input  wire logic                  external_assigned_trips,
    input  wire logic                  current_assigned_trips,
    input  wire logic                  other_assigned_trips,
    input  wire logic [NUM_EXTRA-1:0]  extra_trigger_input,
    // Breaker opening indications
    input  wire logic                  breaker_open_position,
    input  wire logic                  current_below_threshold,
    // External protection and intertripping inputs
    input  wire logic [NUM_STAGES-1:0] exp_alarm_input,
    input  wire logic [NUM_STAGES-1:0] exp_trip_input,
    input  wire logic [NUM_STAGES-1:0] external_block_input,
    input  wire logic                  intertrip_input,
    // Supervisor outputs
    output var  logic                  failure_trip,
    output var  logic                  failure_lock,
    // External protection and intertripping outputs
    output var  logic [NUM_STAGES-1:0] exp_alarm,
    output var  logic [NUM_STAGES-1:0] exp_trip,
    output var  logic                  intertrip_trip,
    output var  logic                  local_trip
);

    localparam int NPIN = 2 * NUM_STAGES + NUM_STAGES + NUM_EXTRA + 6;

    // Pin synchronisers; the first stage feeds only the second
    logic [NPIN-1:0] pin_meta;
    logic [NPIN-1:0] pin_sync;
    wire  [NPIN-1:0] pin_raw = {exp_alarm_input, exp_trip_input, external_block_input,
                                extra_trigger_input, intertrip_input, current_below_threshold,
                                breaker_open_position, other_assigned_trips,
                                current_assigned_trips, external_assigned_trips};

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            pin_meta <= '0;
            pin_sync <= '0;
        end else begin
            pin_meta <= pin_raw;
            pin_sync <= pin_meta;
        end
    end

    wire                  s_ext_trip  = pin_sync[0];
    wire                  s_cur_trip  = pin_sync[1];
    wire                  s_oth_trip  = pin_sync[2];
    wire                  s_pos_open  = pin_sync[3];
    wire                  s_cur_low   = pin_sync[4];
    wire                  s_intertrip = pin_sync[5];
    wire [NUM_EXTRA-1:0]  s_extra     = pin_sync[6 +: NUM_EXTRA];
    wire [NUM_STAGES-1:0] s_block     = pin_sync[6 + NUM_EXTRA +: NUM_STAGES];
    wire [NUM_STAGES-1:0] s_exp_trip  = pin_sync[6 + NUM_EXTRA + NUM_STAGES +: NUM_STAGES];
    wire [NUM_STAGES-1:0] s_exp_alarm = pin_sync[6 + NUM_EXTRA + 2 * NUM_STAGES +: NUM_STAGES];

    // Software-visible settings
    logic [31:0]     ctrl;
    logic [31:0]     fail_time;
    wire mode_field_t   trig_mode  = ctrl[`CTRL_MODE_LSB +: 2];
    wire scheme_field_t scheme     = ctrl[`CTRL_SCHEME_LSB +: 2];
    wire [NUM_STAGES-1:0] exp_mode = ctrl[`CTRL_EXP_LSB +: NUM_STAGES];
    wire                  itrip_en = ctrl[`CTRL_ITRIP_BIT];

    // Avalon decode; a request completes on the edge where waitrequest is low
    wire bus_req    = avs_read | avs_write;
    wire bus_accept = bus_req & ~avs_waitrequest;
    wire wr_ctrl    = avs_write & bus_accept & (avs_address == `REG_CTRL);
    wire wr_time    = avs_write & bus_accept & (avs_address == `REG_TIME);
    wire lock_ack   = avs_write & bus_accept & (avs_address == `REG_ACK)
                      & avs_writedata[`ACK_LOCK_BIT];

    // Trigger selection
    wire all_trips = s_ext_trip | s_cur_trip | s_oth_trip;                     // [RL11]
    wire sel_trips = (trig_mode == `MODE_ALL)      ? all_trips :
                     (trig_mode == `MODE_EXTERNAL) ? s_ext_trip :             // [RL12]
                     (trig_mode == `MODE_CURRENT)  ? s_cur_trip : 1'b0;       // [RL13] [RL14]
    wire trigger   = sel_trips | (|s_extra);                                   // [RL15] [RL20]

    // Opening detection per scheme
    wire opened = (scheme == `SCHEME_POSITION) ? s_pos_open :                 // [RL5] [RL6]
                  (scheme == `SCHEME_CURRENT)  ? s_cur_low :
                  (scheme == `SCHEME_BOTH)     ? (s_pos_open & s_cur_low) :
                                                 (s_pos_open | s_cur_low);    // [RL5]

    // Supervision timer in microsecond ticks
    sup_state_t  state;
    sup_state_t  next_state;
    logic [15:0] prescale;
    logic [31:0] elapsed_us;
    wire         us_tick = (prescale == TICK_CYCLES - 16'h1);
    wire         expired = (elapsed_us >= fail_time);                         // [RL3]
    wire         start   = (state == ST_STANDBY) & trigger;                   // [RL1]

    always_comb begin
        next_state = state;
        case (state)
            ST_STANDBY: begin
                if (trigger) begin
                    next_state = ST_RUNNING;                                   // [RL1]
                end
            end
            ST_RUNNING: begin
                if (opened) begin
                    next_state = trigger ? ST_REJECTED : ST_STANDBY;           // [RL4] [RL7]
                end else if (expired) begin
                    next_state = ST_TRIPPED;                                   // [RL3] [RL6]
                end
            end
            ST_TRIPPED: begin
                if (opened) begin
                    next_state = trigger ? ST_REJECTED : ST_STANDBY;
                end
            end
            ST_REJECTED: begin
                if (!trigger) begin
                    next_state = ST_STANDBY;                                   // [RL8]
                end
            end
            default: begin
                next_state = ST_STANDBY;
            end
        endcase
    end

    wire lock_set   = (state == ST_RUNNING) & (next_state == ST_TRIPPED);      // [RL9]
    wire next_lock  = lock_set | (failure_lock & ~lock_ack);                    // [RL9] [RL10]

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            state <= ST_STANDBY;
        end else begin
            state <= next_state;
        end
    end

    // Timer only counts while running; the trigger no longer matters then
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            prescale   <= 16'h0;
            elapsed_us <= 32'h0;
        end else if (start || state != ST_RUNNING) begin
            prescale   <= 16'h0;
            elapsed_us <= 32'h0;
        end else if (us_tick) begin
            prescale   <= 16'h0;
            elapsed_us <= elapsed_us + 32'h1;                                   // [RL2]
        end else begin
            prescale   <= prescale + 16'h1;
        end
    end

    // Set wins over the acknowledge in the same cycle
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            failure_trip <= 1'b0;
            failure_lock <= 1'b0;
        end else begin
            failure_trip <= (next_state == ST_TRIPPED);                         // [RL3]
            failure_lock <= next_lock;                                          // [RL9] [RL10]
        end
    end

    // External protection stages and intertripping
    wire [NUM_STAGES-1:0] stage_live   = exp_mode & ~s_block;                  // [RL18]
    wire [NUM_STAGES-1:0] next_ealarm  = stage_live & s_exp_alarm;             // [RL17]
    wire [NUM_STAGES-1:0] next_etrip   = stage_live & s_exp_trip;              // [RL16] [RL17]
    wire                  next_itrip   = itrip_en & s_intertrip;               // [RL19]

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            exp_alarm      <= '0;
            exp_trip       <= '0;
            intertrip_trip <= 1'b0;
            local_trip     <= 1'b0;
        end else begin
            exp_alarm      <= next_ealarm;
            exp_trip       <= next_etrip;
            intertrip_trip <= next_itrip;
            local_trip     <= (|next_etrip) | next_itrip;                      // [RL19]
        end
    end

    // Register file and bus answer; one wait state keeps readdata registered
    wire [31:0] status_word = {17'h0, opened, trigger, intertrip_trip,
                               4'(exp_trip), 4'(exp_alarm), failure_lock,
                               failure_trip, 2'(state)};
    wire [31:0] rd_mux = (avs_address == `REG_CTRL)   ? ctrl :
                         (avs_address == `REG_TIME)   ? fail_time :
                         (avs_address == `REG_STATUS) ? status_word : 32'h0;

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            ctrl      <= `CTRL_RST;
            fail_time <= FAIL_TIME_US;
        end else begin
            if (wr_ctrl) begin
                ctrl <= avs_writedata;
            end
            if (wr_time) begin
                fail_time <= avs_writedata;
            end
        end
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            avs_waitrequest <= 1'b1;
            avs_readdata    <= 32'h0;
        end else begin
            avs_waitrequest <= ~(bus_req & avs_waitrequest);
            if (avs_read && avs_waitrequest) begin
                avs_readdata <= rd_mux;
            end
        end
    end

    // Checks
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);

    a_timer_start: assert property (                                           // [RL1]
        state == ST_STANDBY && trigger |=> state == ST_RUNNING && elapsed_us == 32'h0)
        else $error("supervision did not start on trigger");

    a_timer_holds: assert property (                                           // [RL2]
        state == ST_RUNNING && !trigger && !opened && !expired |=> state == ST_RUNNING)
        else $error("timer stopped when trigger dropped");

    a_trip_expiry: assert property (                                           // [RL3]
        state == ST_RUNNING && expired && !opened |=> failure_trip && state == ST_TRIPPED)
        else $error("no failure trip after expiry");

    a_stop_no_trip: assert property (                                          // [RL4]
        state == ST_RUNNING && opened |=> !failure_trip [*2])
        else $error("failure trip despite breaker opening");

    a_scheme_both: assert property (                                           // [RL5]
        state == ST_RUNNING && scheme == `SCHEME_BOTH && !s_cur_low && !expired
        |=> state == ST_RUNNING)
        else $error("both-scheme stopped without low current");

    a_scheme_pos: assert property (                                            // [RL6]
        state == ST_RUNNING && scheme == `SCHEME_POSITION && !s_pos_open
        |=> state inside {ST_RUNNING, ST_TRIPPED})
        else $error("position scheme stopped without open report");

    a_rejected_enter: assert property (                                        // [RL7]
        state == ST_RUNNING && opened && trigger |=> state == ST_REJECTED)
        else $error("rejected state not entered");

    a_rejected_exit: assert property (                                         // [RL8]
        state == ST_REJECTED && !trigger |=> state == ST_STANDBY)
        else $error("rejected state did not return to standby");

    a_lock_with_trip: assert property (                                        // [RL9]
        $rose(failure_trip) |-> failure_lock)
        else $error("lock not issued with failure trip");

    a_lock_held: assert property (                                             // [RL10]
        failure_lock && !lock_ack |=> failure_lock)
        else $error("lock cleared without acknowledge");

    a_mode_none: assert property (                                             // [RL14]
        trig_mode == `MODE_NONE |-> trigger == (|s_extra))
        else $error("assigned trip started supervisor in mode none");

    a_mode_ext: assert property (                                              // [RL12]
        trig_mode == `MODE_EXTERNAL && s_extra == '0 |-> trigger == s_ext_trip)
        else $error("external mode trigger mismatch");

    a_exp_ignored: assert property (                                           // [RL18]
        ##1 (exp_trip & ~$past(exp_mode)) == '0 && (exp_alarm & ~$past(exp_mode)) == '0)
        else $error("disabled stage produced an event");

    a_intertrip: assert property (                                             // [RL19]
        itrip_en && s_intertrip |=> intertrip_trip && local_trip)
        else $error("intertrip not issued");

    // Bus answer: exactly one wait state, then waitrequest high again
    a_bus_one_wait: assert property (
        bus_req && avs_waitrequest |=> !avs_waitrequest)
        else $error("bus request not answered after one wait state");

    a_bus_single_ack: assert property (
        !avs_waitrequest |=> avs_waitrequest)
        else $error("waitrequest low for more than one cycle");

    // Trigger sources, then rejected state, timer, trip, lock, stage and local trip checks
    a_mode_all: assert property (                                              // [RL11]
        trig_mode == `MODE_ALL && s_extra == '0
        |-> trigger == (s_ext_trip | s_cur_trip | s_oth_trip))
        else $error("all-trips mode trigger mismatch");

    a_mode_cur: assert property (                                              // [RL13]
        trig_mode == `MODE_CURRENT && s_extra == '0
        |-> trigger == s_cur_trip)
        else $error("current mode trigger mismatch");

    a_extra_starts: assert property (                                          // [RL15]
        state == ST_STANDBY && |s_extra |=> state == ST_RUNNING)
        else $error("extra trigger did not start supervision");

    a_extra_forces_trig: assert property (                                     // [RL20]
        |s_extra |-> trigger)
        else $error("extra trigger missing from effective trigger");

    a_rejected_hold: assert property (                                         // [RL7]
        state == ST_REJECTED && trigger |=> state == ST_REJECTED)
        else $error("rejected state left while trigger active");

    a_timer_count: assert property (                                           // [RL2]
        state == ST_RUNNING && us_tick && !opened && !expired
        |=> elapsed_us == $past(elapsed_us) + 32'h1)
        else $error("supervision timer did not advance");

    a_trip_from_run: assert property (                                         // [RL3]
        $rose(failure_trip) |-> $past(state) == ST_RUNNING)
        else $error("failure trip without running timer");

    a_trip_level: assert property (                                            // [RL3]
        failure_trip |-> state == ST_TRIPPED)
        else $error("failure trip outside tripped state");

    a_lock_set_wins: assert property (                                         // [RL9]
        lock_set |=> failure_lock)
        else $error("lock not set on failure trip");

    a_ack_clears: assert property (                                            // [RL10]
        failure_lock && lock_ack && !lock_set
        |=> !failure_lock)
        else $error("acknowledge did not clear lock");

    a_stage_trip: assert property (                                            // [RL17]
        (exp_mode & ~s_block & s_exp_trip) != '0
        |=> exp_trip != '0)
        else $error("enabled stage trip not issued");

    a_block_stage: assert property (                                           // [RL17]
        ##1 ((exp_trip & $past(s_block)) == '0))
        else $error("blocked stage produced a trip");

    a_local_trip: assert property (                                            // [RL19]
        exp_trip != '0 || intertrip_trip
        |-> local_trip)
        else $error("local trip missing");

    c_failure_trip: cover property (state == ST_RUNNING ##1 state == ST_TRIPPED);
    c_rejected:     cover property (state == ST_RUNNING ##1 state == ST_REJECTED);
    c_clean_open:   cover property (state == ST_RUNNING ##1 state == ST_STANDBY);
    c_lock_ack:     cover property (failure_lock ##1 !failure_lock);
    c_extra_start:  cover property (state == ST_STANDBY && |s_extra ##1 state == ST_RUNNING);

endmodule : breaker_failure_supervision
`default_nettype wire

// ### breaker_failure_supervision_tb.sv
`include "bfs_cfg.svh"
`default_nettype none
module breaker_failure_supervision_tb;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct {logic [31:0] exp; logic [31:0] mask;} note_t;
    logic        ref_clk = 1'b0, sys_rst = 1'b1;
    logic [3:0]  avs_address = 4'h0;
    logic        avs_read = 1'b0, avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0, avs_readdata;
    logic        avs_waitrequest, failure_trip, failure_lock, intertrip_trip, local_trip;
    logic        ext_trg = 1'b0, cur_trg = 1'b0, oth_trg = 1'b0, itrip_in = 1'b0;
    logic [2:0]  extra = 3'h0;
    logic        open_pos = 1'b0, open_cur = 1'b0, pos_ind, cur_low;
    logic [7:0]  lag = 8'h00;
    logic [3:0]  al_in = 4'h0, tr_in = 4'h0, bl_in = 4'h0, exp_alarm, exp_trip;
    note_t       notes[$];
    note_t       n;
    int          bad_count = 0, tests_run = 0, cycles = 0;
    int          m, s, sc;
    logic [3:0]  src, en, al, tr, bl;
    logic        it, ie, stop;
    always #2 ref_clk = ~ref_clk;
    breaker_failure_supervision #(.TICK_CYCLES(16'h0004)) dut_u (
        .ref_clk(ref_clk), .sys_rst(sys_rst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .external_assigned_trips(ext_trg), .current_assigned_trips(cur_trg),
        .other_assigned_trips(oth_trg), .extra_trigger_input(extra),
        .breaker_open_position(pos_ind), .current_below_threshold(cur_low),
        .exp_alarm_input(al_in), .exp_trip_input(tr_in), .external_block_input(bl_in),
        .intertrip_input(itrip_in), .failure_trip(failure_trip), .failure_lock(failure_lock),
        .exp_alarm(exp_alarm), .exp_trip(exp_trip), .intertrip_trip(intertrip_trip),
        .local_trip(local_trip));
    breaker_partner partner_u (
        .ref_clk(ref_clk), .open_pos_req(open_pos), .open_cur_req(open_cur), .lag(lag),
        .breaker_open_position(pos_ind), .current_below_threshold(cur_low));
    task automatic finish_test;
        if (bad_count == 0 && tests_run > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : finish_test
    // Request held until waitrequest is sampled low; one idle edge keeps strobes single-driven
    task automatic bus_write(input logic [3:0] a, input logic [31:0] d);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= 1'b1;
        do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
        avs_write <= 1'b0;
        @(posedge ref_clk);
    endtask : bus_write
    task automatic bus_read(input logic [3:0] a, input logic [31:0] e, input logic [31:0] k);
        notes.push_back('{e, k});
        avs_address <= a;
        avs_read <= 1'b1;
        do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
        avs_read <= 1'b0;
        @(posedge ref_clk);
    endtask : bus_read
    // Monitor takes the oldest note at each accepted read
    always @(posedge ref_clk) begin
        if (avs_read === 1'b1 && avs_waitrequest === 1'b0 && notes.size() > 0) begin
            n = notes.pop_front();
            tests_run++;
            if ((avs_readdata & n.mask) !== (n.exp & n.mask)) begin
                $display("CHECK FAILED readdata expected %h seen %h", n.exp & n.mask,
                         avs_readdata & n.mask);
                bad_count++;
            end
        end
    end
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles > 20000) begin
            bad_count++;
            finish_test();
        end
    end
    initial begin
        void'($urandom(25));
        repeat (16) @(posedge ref_clk);
        sys_rst <= 1'b0;
        @(posedge ref_clk);
        bus_read(`REG_CTRL, `CTRL_RST, 32'hffff_ffff);
        bus_read(`REG_TIME, `TIME_RST_US, 32'hffff_ffff);
        bus_write(4'h2, 32'hffff_ffff);
        bus_read(4'h2, 32'h0, 32'hffff_ffff);
        // Trigger selection per mode; breaker shown open so each start is rejected
        open_pos <= 1'b1;
        for (m = 0; m < 4; m++) begin
            bus_write(`REG_CTRL, 32'(m));
            for (s = 0; s < 4; s++) begin
                src = 4'h1 << s;
                {oth_trg, cur_trg, ext_trg} <= src[2:0];
                extra <= src[3] ? 3'(3'h1 << ($urandom % 3)) : 3'h0;
                stop = src[3] | (m == 0 && |src[2:0]) | (m == 1 && src[0]) | (m == 2 && src[1]);
                repeat (6) @(posedge ref_clk);
                bus_read(`REG_STATUS, 32'(stop) << 13,
                         32'h2000);
                {oth_trg, cur_trg, ext_trg, extra} <= 6'h00;
                repeat (8) @(posedge ref_clk);
            end
        end
        // Short trigger pulse, timer runs on to expiry
        open_pos <= 1'b0;
        bus_write(`REG_CTRL, 32'h0);
        bus_write(`REG_TIME, 32'h3);
        ext_trg <= 1'b1;
        repeat (3) @(posedge ref_clk);
        ext_trg <= 1'b0;
        repeat (30) @(posedge ref_clk);
        bus_read(`REG_STATUS, 32'he, 32'hf);
        if (failure_trip !== 1'b1 || failure_lock !== 1'b1) begin
            $display("CHECK FAILED trip/lock expected 11 seen %b%b", failure_trip, failure_lock);
            bad_count++;
        end
        tests_run++;
        open_pos <= 1'b1;
        repeat (10) @(posedge ref_clk);
        bus_read(`REG_STATUS, 32'h8, 32'hf);
        bus_write(`REG_ACK, 32'h1);
        bus_read(`REG_STATUS, 32'h0, 32'hf);
        bus_read(`REG_ACK, 32'h0, 32'hffff_ffff);
        // Each scheme with the position indication first, low current added later, slow breaker
        bus_write(`REG_TIME, 32'd20);
        for (sc = 0; sc < 4; sc++) begin
            open_pos <= 1'b0;
            open_cur <= 1'b0;
            lag <= 8'($urandom % 16);
            bus_write(`REG_CTRL, 32'(sc) << `CTRL_SCHEME_LSB);
            ext_trg <= 1'b1;
            stop = (sc == 0 || sc == 3);
            repeat (10) @(posedge ref_clk);
            open_pos <= 1'b1;
            repeat (40) @(posedge ref_clk);
            bus_read(`REG_STATUS, stop ? 32'h3 : 32'h1, 32'hf);
            repeat (60) @(posedge ref_clk);
            bus_read(`REG_STATUS, stop ? 32'h3 : 32'he, 32'hf);
            ext_trg <= 1'b0;
            open_cur <= 1'b1;
            repeat (30) @(posedge ref_clk);
            bus_read(`REG_STATUS, stop ? 32'h0 : 32'h8, 32'hf);
            bus_write(`REG_ACK, 32'h1);
        end
        // External protection stages and intertripping with random inputs
        for (m = 0; m < 10; m++) begin
            {en, al, tr, bl, it, ie} = 18'($urandom);
            bus_write(`REG_CTRL, {23'h0, ie, en, 4'h0});
            al_in <= al;
            tr_in <= tr;
            bl_in <= bl;
            itrip_in <= it;
            repeat (6) @(posedge ref_clk);
            bus_read(`REG_STATUS, {19'h0, ie & it, en & ~bl & tr, en & ~bl & al, 4'h0},
                     32'h1ff0);
            if (local_trip !== ((|(en & ~bl & tr)) | (ie & it))) begin
                $display("CHECK FAILED local_trip expected %b seen %b",
                         (|(en & ~bl & tr)) | (ie & it), local_trip);
                bad_count++;
            end
            tests_run++;
        end
        finish_test();
    end
endmodule : breaker_failure_supervision_tb
`default_nettype wire

// ### breaker_partner.sv
`default_nettype none
module breaker_partner (
    // Clock
    input  wire logic       ref_clk,
    // Opening requests from the bench
    input  wire logic       open_pos_req,
    input  wire logic       open_cur_req,
    input  wire logic [7:0] lag,
    // Breaker indications
    output var  logic       breaker_open_position,
    output var  logic       current_below_threshold
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] pos_cnt = 8'h00;
    logic [7:0] cur_cnt = 8'h00;
    // Contacts and current fall back at once; a slow breaker opens only after lag cycles
    always @(posedge ref_clk) begin
        if (!open_pos_req) begin
            pos_cnt <= 8'h00;
            breaker_open_position <= 1'b0;
        end else if (pos_cnt >= lag) begin
            breaker_open_position <= 1'b1;
        end else begin
            pos_cnt <= pos_cnt + 8'h01;
        end
        if (!open_cur_req) begin
            cur_cnt <= 8'h00;
            current_below_threshold <= 1'b0;
        end else if (cur_cnt >= lag) begin
            current_below_threshold <= 1'b1;
        end else begin
            cur_cnt <= cur_cnt + 8'h01;
        end
    end
endmodule : breaker_partner
`default_nettype wire
